// >>> hw/srm_pkg.sv
// Purpose: Shared constants and carrier types for the supply and resonance
//          monitor.
// Assumes: 50 MHz core clock.
// Notes: Register offsets are byte addresses on the register port.
package srm_pkg;
  localparam logic [7:0] SUPPLY_VOLTAGE_READING_ADDR = 8'h21;
  localparam logic [7:0] RESONANCE_PERIOD_READING_ADDR = 8'h22;
  localparam logic [7:0] SUPPLY_VOLTAGE_READING_RST = 8'h00;
  localparam logic [7:0] RESONANCE_PERIOD_READING_RST = 8'h00;
  // Code scale: volts = code * 5.6 / 255
  localparam int VDD_FULL_MV = 5600;
  localparam int VDD_CODE_MAX = 255;
  // Period code LSB in nanoseconds (98.46 us)
  localparam int PERIOD_LSB_NS = 98460;
  localparam int CLK_PERIOD_NS = 20;
  localparam int PERIOD_LSB_CYC = PERIOD_LSB_NS / CLK_PERIOD_NS;
  localparam int CYC_W = 13;
  localparam int NUM_READINGS = 2;
  localparam logic [0:0] IDX_SUPPLY = 1'h0;
  localparam logic [0:0] IDX_PERIOD = 1'h1;

  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } srm_reg_req_t;

  typedef struct packed {
    logic drive_pos;
    logic drive_neg;
  } srm_drive_t;
endpackage

// >>> hw/srm_mem.sv
// Purpose: Two-entry storage for the measurement readings.
// Assumes: One write port, one registered read port.
// Notes: Read data comes from a register.
`timescale 1ns/1ns
module srm_mem #(
  parameter int DEPTH = 2,
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_idx,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [$clog2(DEPTH)-1:0] rd_idx,
  output logic [WIDTH-1:0] rd_data
);
  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      for (int i = 0; i < DEPTH; i++)
        mem[i] <= '0;
      rd_data <= '0;
    end
    else if (clk_en)
    begin
      if (wr_en)
        mem[wr_idx] <= wr_data;
      rd_data <= mem[rd_idx];
    end
  end
endmodule

// >>> hw/srm_top.sv
// Purpose: Supply and resonance measurement with register readback.
// Assumes: Supply code comes from an on-chip converter on this clock;
//          back-EMF comparator arrives asynchronously.
// Notes: Register writes store a value until the next measurement; a write in a cycle where any measurement lands is dropped.
`timescale 1ns/1ns
module srm_top #(
  parameter int CNT_W = 24
) (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire srm_pkg::srm_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic drive_active,
  input wire logic drive_polarity,
  input wire logic [7:0] supply_sample,
  input wire logic supply_sample_valid,
  input wire logic level_cal_busy,
  input wire logic bemf_sign,
  output logic drive_pos,
  output logic drive_neg,
  output logic resonance_locked,
  output logic [CNT_W-1:0] half_period_cycles
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEEK = 3'b010,
    ST_TRACK = 3'b100
  } srm_state_t;

  typedef struct packed {
    srm_state_t st;
    logic [1:0] bemf_sync;
    logic bemf_prev;
    logic [CNT_W-1:0] half_cnt;
    logic [CNT_W-1:0] half_est;
    logic [CNT_W-1:0] full_acc;
    logic half_phase;
    logic locked;
    logic rd_pend;
    logic [7:0] rdata;
    logic rvalid;
    srm_pkg::srm_drive_t drv;
  } srm_regs_t;

  srm_regs_t r;
  srm_regs_t next_r;

  logic mem_wr;
  logic [0:0] mem_widx;
  logic [7:0] mem_wdata;
  logic [0:0] mem_ridx;
  logic [7:0] mem_rdata;
  logic bemf_edge;
  logic [CNT_W-1:0] full_period;
  logic [7:0] period_code;

  function automatic logic [0:0] addr_idx(input logic [7:0] a);
    addr_idx = (a == srm_pkg::RESONANCE_PERIOD_READING_ADDR) ?
      srm_pkg::IDX_PERIOD : srm_pkg::IDX_SUPPLY;
  endfunction

  function automatic logic addr_hit(input logic [7:0] a);
    addr_hit = (a == srm_pkg::SUPPLY_VOLTAGE_READING_ADDR) ||
      (a == srm_pkg::RESONANCE_PERIOD_READING_ADDR);
  endfunction

  assign bemf_edge = r.bemf_sync[1] ^ r.bemf_prev;
  assign full_period = r.full_acc + r.half_cnt;
  // Saturating conversion to 98.46 us steps
  always_comb
  begin
    logic [CNT_W-1:0] q;
    q = full_period / CNT_W'(srm_pkg::PERIOD_LSB_CYC);
    period_code = (q > CNT_W'(255)) ? 8'hff : q[7:0];
  end

  srm_mem #(
    .DEPTH(srm_pkg::NUM_READINGS),
    .WIDTH(8)
  ) srm_mem_inst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .wr_en(mem_wr),
    .wr_idx(mem_widx),
    .wr_data(mem_wdata),
    .rd_idx(mem_ridx),
    .rd_data(mem_rdata)
  );

  always_comb
  begin
    next_r = r;
    mem_wr = 1'b0;
    mem_widx = srm_pkg::IDX_SUPPLY;
    mem_wdata = 8'h00;
    mem_ridx = addr_idx(reg_req.addr);
    next_r.bemf_sync = {r.bemf_sync[0], bemf_sign};
    next_r.bemf_prev = r.bemf_sync[1];
    // Read answer one cycle after memory read
    next_r.rd_pend = reg_req.rd_en;
    next_r.rvalid = r.rd_pend;
    if (r.rd_pend)
      next_r.rdata = mem_rdata;
    // Differential stage: polarity picks the sourcing leg
    next_r.drv.drive_pos = drive_active && drive_polarity;
    next_r.drv.drive_neg = drive_active && !drive_polarity;
    // Level calibration has no path into tracking
    unique case (r.st)
      ST_IDLE:
      begin
        next_r.half_cnt = '0;
        next_r.full_acc = '0;
        next_r.half_phase = 1'b0;
        next_r.locked = 1'b0;
        if (drive_active)
          next_r.st = ST_SEEK;
      end
      ST_SEEK, ST_TRACK:
      begin
        if (r.half_cnt != '1)
          next_r.half_cnt = r.half_cnt + CNT_W'(1);
        if (!drive_active)
          next_r.st = ST_IDLE;
        else if (bemf_edge)
        begin
          // Edge cycle already belongs to the new half
          next_r.half_cnt = CNT_W'(1);
          if (r.st == ST_SEEK)
          begin
            // First crossing: half-cycle estimate, lock
            next_r.half_est = r.half_cnt;
            next_r.locked = 1'b1;
            // Full cycle pairing starts at the next crossing
            next_r.half_phase = 1'b0;
            next_r.full_acc = r.half_cnt;
            next_r.st = ST_TRACK;
          end
          else
          begin
            next_r.half_est = r.half_cnt;
            next_r.half_phase = !r.half_phase;
            if (r.half_phase)
            begin
              // Full drive cycle closed: refresh period
              mem_wr = 1'b1;
              mem_widx = srm_pkg::IDX_PERIOD;
              mem_wdata = period_code;
            end
            else
              next_r.full_acc = r.half_cnt;
          end
        end
      end
    endcase
    // Supply sample takes the write port while drive_active when no period update is due
    if (drive_active && supply_sample_valid && !mem_wr)
    begin
      mem_wr = 1'b1;
      mem_widx = srm_pkg::IDX_SUPPLY;
      mem_wdata = supply_sample;
    end
    // Software writes store only when no measurement lands
    if (reg_req.wr_en && addr_hit(reg_req.addr) && !mem_wr)
    begin
      mem_wr = 1'b1;
      mem_widx = addr_idx(reg_req.addr);
      mem_wdata = reg_req.wdata;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      r <= '0;
      r.st <= ST_IDLE;
    end
    else if (clk_en)
      r <= next_r;
  end

  assign reg_rdata = r.rdata;
  assign reg_rvalid = r.rvalid;
  assign drive_pos = r.drv.drive_pos;
  assign drive_neg = r.drv.drive_neg;
  assign resonance_locked = r.locked;
  assign half_period_cycles = r.half_est;

  a_idle_no_write: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && !drive_active && mem_wr |-> reg_req.wr_en)
    else $error("measurement written while idle");

  a_legs_exclusive: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !(drive_pos && drive_neg))
    else $error("both output legs active");

  a_lock_first_edge: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && r.st == ST_SEEK && drive_active && bemf_edge
    |=> !clk_en or resonance_locked)
    else $error("no lock after first crossing");

  sequence s_track_full;
    clk_en && r.st == ST_TRACK && drive_active && bemf_edge &&
    r.half_phase;
  endsequence
  a_cycle_update: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_track_full |-> mem_wr && mem_widx == srm_pkg::IDX_PERIOD)
    else $error("period not refreshed at cycle end");

  a_bemf_edge: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && r.st == ST_TRACK && drive_active && bemf_edge
    |=> !clk_en or half_period_cycles == $past(r.half_cnt))
    else $error("half period estimate not captured");

  a_cal_indep: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && r.st == ST_IDLE && drive_active
    |=> !clk_en or r.st == ST_SEEK)
    else $error("tracking start blocked");

  a_supply_store: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    clk_en && drive_active && supply_sample_valid &&
    !(mem_wr && mem_widx == srm_pkg::IDX_PERIOD)
    |-> mem_wr && mem_widx == srm_pkg::IDX_SUPPLY &&
    mem_wdata == supply_sample)
    else $error("supply sample not stored");

  sequence s_read_req;
    clk_en && reg_req.rd_en ##1 clk_en;
  endsequence
  a_read_answer: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    s_read_req |=> reg_rvalid)
    else $error("read not answered in two cycles");

  a_period_scale: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    mem_wr && mem_widx == srm_pkg::IDX_PERIOD && !reg_req.wr_en
    |-> int'(mem_wdata) * srm_pkg::PERIOD_LSB_CYC <= int'(full_period) &&
    (mem_wdata == 8'hff ||
    int'(full_period) < (int'(mem_wdata) + 1) * srm_pkg::PERIOD_LSB_CYC))
    else $error("period code scale wrong");
endmodule

// >>> verification/srm_act_model.sv
// Purpose: Actuator stand-in whose back-EMF sign flips each half period.
// Assumes: Half period in clocks is set live by the bench.
// Notes: Sign stands still while both drive legs are idle.
`timescale 1ns/1ns
module srm_act_model (
  input wire logic core_clk,
  input wire logic drive_pos,
  input wire logic drive_neg,
  input wire logic [15:0] half_cyc,
  output logic bemf_sign
);
  logic [15:0] cnt;
  initial
  begin
    cnt = 16'h0000;
    bemf_sign = 1'b0;
  end
  always @(posedge core_clk)
  begin
    if (drive_pos || drive_neg)
    begin
      if (cnt + 16'h0001 >= half_cyc)
      begin
        cnt <= 16'h0000;
        bemf_sign <= ~bemf_sign;
      end
      else
      begin
        cnt <= cnt + 16'h0001;
      end
    end
  end
endmodule

// >>> verification/supply_and_resonance_monitor_tb.sv
// Purpose: Self-checking bench for the supply and resonance monitor.
// Assumes: Clock enable high except in the freeze check.
// Notes: Period codes follow from the chosen model half periods.
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin \
  n_fail++; $display("[FAIL] %s exp %h got %h", nm, ex, got); end end
module supply_and_resonance_monitor_tb;
  logic core_clk, sys_rst, drive_active, drive_polarity;
  logic clk_en;
  logic supply_sample_valid, level_cal_busy, bemf_sign;
  logic drive_pos, drive_neg, resonance_locked, reg_rvalid;
  logic [7:0] supply_sample, reg_rdata;
  logic [23:0] half_period_cycles;
  logic [15:0] half_cyc;
  srm_pkg::srm_reg_req_t reg_req;
  int n_fail, check_count;
  srm_top #(.CNT_W(24)) srm_top_inst (.core_clk(core_clk),
    .sys_rst(sys_rst), .clk_en(clk_en), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .drive_active(drive_active), .drive_polarity(drive_polarity),
    .supply_sample(supply_sample),
    .supply_sample_valid(supply_sample_valid),
    .level_cal_busy(level_cal_busy), .bemf_sign(bemf_sign),
    .drive_pos(drive_pos), .drive_neg(drive_neg),
    .resonance_locked(resonance_locked),
    .half_period_cycles(half_period_cycles));
  srm_act_model srm_act_model_inst (.core_clk(core_clk),
    .drive_pos(drive_pos), .drive_neg(drive_neg), .half_cyc(half_cyc),
    .bemf_sign(bemf_sign));
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] ex,
    input string nm);
    int i;
    reg_req = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    tick(1);
    reg_req.rd_en = 1'b0;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++)
      tick(1);
    if (i == 4)
    begin
      n_fail++;
      close_out();
    end
    `CHK(nm, ex, reg_rdata)
    tick(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    tick(1);
    reg_req.wr_en = 1'b0;
    tick(1);
  endtask
  task automatic t_reset();
    rd(8'h21, 8'h00, "supply rst");
    rd(8'h22, 8'h00, "period rst");
    `CHK("locked rst", 1'b0, resonance_locked)
    $display("done t_reset");
  endtask
  task automatic t_idle();
    supply_sample = 8'h11;
    supply_sample_valid = 1'b1;
    tick(2);
    supply_sample_valid = 1'b0;
    rd(8'h21, 8'h00, "idle supply");
    $display("done t_idle");
  endtask
  task automatic t_rw();
    wr(8'h21, 8'h5a);
    rd(8'h21, 8'h5a, "supply rw");
    wr(8'h40, 8'hff);
    rd(8'h21, 8'h5a, "unmapped wr");
    wr(8'h22, 8'hc3);
    rd(8'h22, 8'hc3, "period rw");
    rd(8'h40, 8'h5a, "unmapped rd");
    clk_en = 1'b0;
    wr(8'h21, 8'h77);
    clk_en = 1'b1;
    rd(8'h21, 8'h5a, "frozen wr");
    $display("done t_rw");
  endtask
  task automatic t_track();
    int i;
    level_cal_busy = 1'b1;
    drive_polarity = 1'b0;
    drive_active = 1'b1;
    tick(2);
    `CHK("neg leg", 2'b01, {drive_pos, drive_neg})
    drive_polarity = 1'b1;
    supply_sample = 8'hb6;
    supply_sample_valid = 1'b1;
    tick(2);
    supply_sample_valid = 1'b0;
    `CHK("pos leg", 2'b10, {drive_pos, drive_neg})
    rd(8'h21, 8'hb6, "supply live");
    for (i = 0; i < 5100 && resonance_locked !== 1'b1; i++)
      tick(1);
    if (i == 5100)
    begin
      n_fail++;
      close_out();
    end
    `CHK("locked", 1'b1, resonance_locked)
    tick(15000);
    `CHK("half 5000", 24'd5000, half_period_cycles)
    rd(8'h22, 8'h02, "period 2");
    half_cyc = 16'd7400;
    tick(30000);
    `CHK("half 7400", 24'd7400, half_period_cycles)
    rd(8'h22, 8'h03, "period 3");
    drive_active = 1'b0;
    level_cal_busy = 1'b0;
    tick(3);
    `CHK("legs off", 2'b00, {drive_pos, drive_neg})
    supply_sample = 8'h22;
    supply_sample_valid = 1'b1;
    tick(1);
    supply_sample_valid = 1'b0;
    rd(8'h21, 8'hb6, "supply held");
    $display("done t_track");
  endtask
  initial
  begin
    n_fail = 0;
    check_count = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    reg_req = '0;
    drive_active = 1'b0;
    drive_polarity = 1'b0;
    supply_sample = 8'h00;
    supply_sample_valid = 1'b0;
    level_cal_busy = 1'b0;
    half_cyc = 16'd5000;
    tick(20);
    sys_rst = 1'b0;
    t_reset();
    t_idle();
    t_rw();
    t_track();
    close_out();
  end
endmodule
